// ---- hdl/rfb_consts.svh ----
// constants of the received-packet frame builder: bytes, positions, bits
// assumes inclusion by bare name from the frame builder module
//
// Operation
// RULE1 - each received packet leaves as one frame, type 0x90 or 0x91 at position 3.
// RULE2 - plain 0x90 frames are produced only while the format select is 0.
// RULE3 - with format select at 1 a packet leaves as an explicit 0x91 frame.
// RULE4 - 0x7e, then a high-first length counting type through payload bytes.
// RULE5 - the last byte is 0xff minus the low sum byte of position 3 onward.
// RULE6 - positions 4 to 11 hold the 64-bit sender address, top byte first.
// RULE7 - options bit 0 marks an acknowledged packet and bit 1 a broadcast.
// RULE8 - options bits 7:6 carry the delivery method code 01, 10 or 11.
// RULE9 - in the explicit frame position 14 holds the source endpoint.
// RULE10 - in the explicit frame position 15 holds the destination endpoint.
// RULE11 - explicit positions 16, 17 carry the cluster id, high byte first.
// RULE12 - explicit positions 18, 19 carry the profile id, high byte first.
// RULE13 - 12, 13 hold reserved bytes; payload follows the options byte.
`ifndef RFB_CONSTS_SVH
`define RFB_CONSTS_SVH

`define RFB_DELIM        8'h7e
`define RFB_TYPE_PLAIN   8'h90
`define RFB_TYPE_EXPL    8'h91
`define RFB_CSUM_BASE    8'hff
`define RFB_RSV_HI       8'hff
`define RFB_RSV_LO       8'hfe

`define RFB_POS_DELIM    16'd0
`define RFB_POS_LEN_HI   16'd1
`define RFB_POS_LEN_LO   16'd2
`define RFB_POS_TYPE     16'd3
`define RFB_POS_ADDR_MSB 16'd4
`define RFB_POS_ADDR_LSB 16'd11
`define RFB_POS_RSV_HI   16'd12
`define RFB_POS_RSV_LO   16'd13
`define RFB_POS_P_OPT    16'd14
`define RFB_POS_P_DATA   16'd15
`define RFB_POS_SRC_EP   16'd14
`define RFB_POS_DST_EP   16'd15
`define RFB_POS_CLU_HI   16'd16
`define RFB_POS_CLU_LO   16'd17
`define RFB_POS_PRO_HI   16'd18
`define RFB_POS_PRO_LO   16'd19
`define RFB_POS_X_OPT    16'd20
`define RFB_POS_X_DATA   16'd21

`define RFB_OPT_ACK_BIT   0
`define RFB_OPT_BCAST_BIT 1
`define RFB_OPT_METH_LSB  6

`define RFB_RST_BYTE     8'h00
`define RFB_RST_POS      16'h0000

`endif

// ---- hdl/rfb_pkg.sv ----
// types shared by the received-packet frame builder
// assumes the constants header sits beside it
package rfb_pkg;

	// sequencer states; one byte takes fetch, load and hold
	typedef enum logic [2:0] {
		RFB_ST_IDLE  = 3'b000,
		RFB_ST_CAPT  = 3'b001,
		RFB_ST_FETCH = 3'b010,
		RFB_ST_LOAD  = 3'b011,
		RFB_ST_HOLD  = 3'b100
	} rfb_state_t;

endpackage

// ---- hdl/rfb_payload_mem.sv ----
// payload store of the frame builder: one write port, one registered read
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/1ns
module rfb_payload_mem #(
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic          i_clk_sys,
	input  wire logic          i_rst_n,
	input  wire logic          i_wr_en,
	input  wire logic [AW-1:0] i_wr_addr,
	input  wire logic [7:0]    i_wr_data,
	input  wire logic [AW-1:0] i_rd_addr,
	output logic      [7:0]    o_rd_data
);

	logic [7:0] mem_r [DEPTH];

	// array left unreset; only written bytes are ever read back
	always_ff @(posedge i_clk_sys) begin
		if (i_wr_en) begin
			mem_r[i_wr_addr] <= i_wr_data;
		end
	end

	// read data one cycle after the address
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_rd_data <= 8'h00;
		end else begin
			o_rd_data <= mem_r[i_rd_addr];
		end
	end

endmodule // rfb_payload_mem

// ---- hdl/rfb_frame_builder.sv ----
// received-packet frame builder: stores one payload, then emits the
// serial api frame byte by byte toward the uart transmitter
// assumes radio side and uart side on i_clk_sys, uart side drains bytes
`timescale 1ns/1ns
`include "rfb_consts.svh"
module rfb_frame_builder #(
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic        i_api_output_format_select,
	input  wire logic        i_rx_start,  // header fields valid
	input  wire logic [63:0] i_rx_src_addr,
	input  wire logic        i_rx_ack,
	input  wire logic        i_rx_bcast,
	input  wire logic [1:0]  i_rx_method,
	input  wire logic [7:0]  i_rx_src_ep,
	input  wire logic [7:0]  i_rx_dst_ep,
	input  wire logic [15:0] i_rx_cluster,
	input  wire logic [15:0] i_rx_profile,
	input  wire logic        i_rx_valid,  // payload byte
	input  wire logic [7:0]  i_rx_data,
	input  wire logic        i_rx_last,
	output logic             o_rx_ready,
	output logic             o_busy,
	output logic             o_tx_valid,
	output logic [7:0]       o_tx_data,
	output logic             o_tx_last,
	input  wire logic        i_tx_ready
);

	rfb_pkg::rfb_state_t state_r;
	rfb_pkg::rfb_state_t state_nxt;
	logic [15:0]   pos_r;
	logic [15:0]   pos_nxt;
	logic [15:0]   plen_r;
	logic [15:0]   plen_nxt;
	logic [7:0]    sum_r;
	logic [7:0]    sum_nxt;
	logic          fmt_r;
	logic          fmt_nxt;
	logic [63:0]   src_r;
	logic [63:0]   src_nxt;
	logic [7:0]    opt_r;
	logic [7:0]    opt_nxt;
	logic [7:0]    sep_r;
	logic [7:0]    sep_nxt;
	logic [7:0]    dep_r;
	logic [7:0]    dep_nxt;
	logic [15:0]   clu_r;
	logic [15:0]   clu_nxt;
	logic [15:0]   pro_r;
	logic [15:0]   pro_nxt;
	logic          rx_ready_nxt;
	logic          busy_nxt;
	logic          tx_valid_nxt;
	logic [7:0]    tx_data_nxt;
	logic          tx_last_nxt;
	logic [15:0]   data_pos;
	logic [15:0]   len_val;
	logic [15:0]   last_pos;
	logic [2:0]    addr_idx;
	logic [63:0]   addr_sh;
	logic [7:0]    frame_byte;
	logic [7:0]    mem_rd;
	logic [AW-1:0] rd_addr;
	logic          wr_en;

	// frame geometry from the latched format and payload count
	always_comb begin
		data_pos = fmt_r ? `RFB_POS_X_DATA : `RFB_POS_P_DATA; // RULE13
		len_val  = data_pos - `RFB_POS_TYPE + plen_r; // RULE4
		last_pos = data_pos + plen_r;
		addr_idx = 3'(`RFB_POS_ADDR_LSB - pos_r);
		addr_sh  = src_r >> {addr_idx, 3'b000};
		rd_addr  = AW'(pos_r - data_pos);
	end

	// bytes past the store depth are dropped, the count saturates
	assign wr_en = (state_r == rfb_pkg::RFB_ST_CAPT) && i_rx_valid &&
		(plen_r < 16'(DEPTH));

	rfb_payload_mem #(
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_wr_en   (wr_en),
		.i_wr_addr (plen_r[AW-1:0]),
		.i_wr_data (i_rx_data),
		.i_rd_addr (rd_addr),
		.o_rd_data (mem_rd)
	);

	// byte at the current position
	always_comb begin
		frame_byte = `RFB_RST_BYTE;
		if (pos_r == `RFB_POS_DELIM) begin
			frame_byte = `RFB_DELIM; // RULE4
		end else if (pos_r == `RFB_POS_LEN_HI) begin
			frame_byte = len_val[15:8]; // RULE4
		end else if (pos_r == `RFB_POS_LEN_LO) begin
			frame_byte = len_val[7:0]; // RULE4
		end else if (pos_r == `RFB_POS_TYPE) begin
			// RULE1
			frame_byte = fmt_r ? `RFB_TYPE_EXPL : `RFB_TYPE_PLAIN; // RULE2 RULE3
		end else if (pos_r <= `RFB_POS_ADDR_LSB) begin
			frame_byte = addr_sh[7:0]; // RULE6
		end else if (pos_r == `RFB_POS_RSV_HI) begin
			frame_byte = `RFB_RSV_HI; // RULE13
		end else if (pos_r == `RFB_POS_RSV_LO) begin
			frame_byte = `RFB_RSV_LO; // RULE13
		end else if (pos_r == last_pos) begin
			frame_byte = `RFB_CSUM_BASE - sum_r; // RULE5
		end else if (pos_r >= data_pos) begin
			frame_byte = mem_rd; // RULE13
		end else if (!fmt_r) begin
			frame_byte = opt_r; // RULE7
		end else if (pos_r == `RFB_POS_SRC_EP) begin
			frame_byte = sep_r; // RULE9
		end else if (pos_r == `RFB_POS_DST_EP) begin
			frame_byte = dep_r; // RULE10
		end else if (pos_r == `RFB_POS_CLU_HI) begin
			frame_byte = clu_r[15:8]; // RULE11
		end else if (pos_r == `RFB_POS_CLU_LO) begin
			frame_byte = clu_r[7:0]; // RULE11
		end else if (pos_r == `RFB_POS_PRO_HI) begin
			frame_byte = pro_r[15:8]; // RULE12
		end else if (pos_r == `RFB_POS_PRO_LO) begin
			frame_byte = pro_r[7:0]; // RULE12
		end else begin
			frame_byte = opt_r; // RULE7
		end
	end

	// sequencer: latch header, capture payload, then walk the frame
	always_comb begin
		state_nxt    = state_r;
		pos_nxt      = pos_r;
		plen_nxt     = plen_r;
		sum_nxt      = sum_r;
		fmt_nxt      = fmt_r;
		src_nxt      = src_r;
		opt_nxt      = opt_r;
		sep_nxt      = sep_r;
		dep_nxt      = dep_r;
		clu_nxt      = clu_r;
		pro_nxt      = pro_r;
		tx_valid_nxt = o_tx_valid;
		tx_data_nxt  = o_tx_data;
		tx_last_nxt  = o_tx_last;
		unique case (state_r)
			rfb_pkg::RFB_ST_IDLE: begin
				if (i_rx_start) begin
					// format caught per packet, so a change never splits a frame
					fmt_nxt = i_api_output_format_select; // RULE2 RULE3
					src_nxt = i_rx_src_addr;
					opt_nxt = 8'h00;
					opt_nxt[`RFB_OPT_ACK_BIT] = i_rx_ack; // RULE7
					opt_nxt[`RFB_OPT_BCAST_BIT] = i_rx_bcast; // RULE7
					opt_nxt[`RFB_OPT_METH_LSB +: 2] = i_rx_method; // RULE8
					sep_nxt   = i_rx_src_ep;
					dep_nxt   = i_rx_dst_ep;
					clu_nxt   = i_rx_cluster;
					pro_nxt   = i_rx_profile;
					plen_nxt  = `RFB_RST_POS;
					pos_nxt   = `RFB_RST_POS;
					sum_nxt   = `RFB_RST_BYTE;
					state_nxt = rfb_pkg::RFB_ST_CAPT;
				end
			end
			rfb_pkg::RFB_ST_CAPT: begin
				if (i_rx_valid) begin
					if (plen_r < 16'(DEPTH)) begin
						plen_nxt = plen_r + 16'd1;
					end
					if (i_rx_last) begin
						state_nxt = rfb_pkg::RFB_ST_FETCH;
					end
				end
			end
			rfb_pkg::RFB_ST_FETCH: begin
				// gives the store one cycle to present the payload byte
				state_nxt = rfb_pkg::RFB_ST_LOAD;
			end
			rfb_pkg::RFB_ST_LOAD: begin
				tx_valid_nxt = 1'b1;
				tx_data_nxt  = frame_byte;
				tx_last_nxt  = (pos_r == last_pos);
				state_nxt    = rfb_pkg::RFB_ST_HOLD;
			end
			rfb_pkg::RFB_ST_HOLD: begin
				if (i_tx_ready) begin
					tx_valid_nxt = 1'b0;
					tx_last_nxt  = 1'b0;
					if (pos_r >= `RFB_POS_TYPE && !o_tx_last) begin
						sum_nxt = sum_r + o_tx_data; // RULE5
					end
					if (o_tx_last) begin
						state_nxt = rfb_pkg::RFB_ST_IDLE; // RULE1
					end else begin
						pos_nxt   = pos_r + 16'd1;
						state_nxt = rfb_pkg::RFB_ST_FETCH;
					end
				end
			end
			default: begin
				state_nxt = rfb_pkg::RFB_ST_IDLE;
			end
		endcase
		rx_ready_nxt = (state_nxt == rfb_pkg::RFB_ST_CAPT);
		busy_nxt     = (state_nxt != rfb_pkg::RFB_ST_IDLE);
	end

	// state registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_r    <= rfb_pkg::RFB_ST_IDLE;
			pos_r      <= `RFB_RST_POS;
			plen_r     <= `RFB_RST_POS;
			sum_r      <= `RFB_RST_BYTE;
			fmt_r      <= 1'b0;
			src_r      <= 64'h0;
			opt_r      <= `RFB_RST_BYTE;
			sep_r      <= `RFB_RST_BYTE;
			dep_r      <= `RFB_RST_BYTE;
			clu_r      <= 16'h0000;
			pro_r      <= 16'h0000;
			o_rx_ready <= 1'b0;
			o_busy     <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_data  <= `RFB_RST_BYTE;
			o_tx_last  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			pos_r      <= pos_nxt;
			plen_r     <= plen_nxt;
			sum_r      <= sum_nxt;
			fmt_r      <= fmt_nxt;
			src_r      <= src_nxt;
			opt_r      <= opt_nxt;
			sep_r      <= sep_nxt;
			dep_r      <= dep_nxt;
			clu_r      <= clu_nxt;
			pro_r      <= pro_nxt;
			o_rx_ready <= rx_ready_nxt;
			o_busy     <= busy_nxt;
			o_tx_valid <= tx_valid_nxt;
			o_tx_data  <= tx_data_nxt;
			o_tx_last  <= tx_last_nxt;
		end
	end

	// checker side: running sum of emitted bytes from the type byte on
	logic [7:0] chk_r;
	logic       hs;
	assign hs = o_tx_valid && i_tx_ready;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || state_r == rfb_pkg::RFB_ST_IDLE) begin
			chk_r <= 8'h00;
		end else if (hs && pos_r >= `RFB_POS_TYPE) begin
			chk_r <= chk_r + o_tx_data;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	AST_DELIM: assert property ( // RULE4
		o_tx_valid && pos_r == `RFB_POS_DELIM |-> o_tx_data == `RFB_DELIM)
		else $error("frame does not open with the delimiter");
	AST_LEN: assert property ( // RULE4
		hs && pos_r == `RFB_POS_LEN_HI |-> ##[1:4] o_tx_valid &&
		o_tx_data == len_val[7:0] && {$past(o_tx_data, 3), o_tx_data} ==
		data_pos - `RFB_POS_TYPE + plen_r)
		else $error("length field does not match the frame");
	AST_TYPE_PLAIN: assert property ( // RULE1
		o_tx_valid && pos_r == `RFB_POS_TYPE && !fmt_r |->
		o_tx_data == `RFB_TYPE_PLAIN)
		else $error("plain frame carries a wrong type byte");
	AST_FMT_ZERO: assert property ( // RULE2
		i_rx_start && state_r == rfb_pkg::RFB_ST_IDLE &&
		!i_api_output_format_select |=> !fmt_r)
		else $error("plain format not taken with select at zero");
	AST_TYPE_EXPL: assert property ( // RULE3
		o_tx_valid && pos_r == `RFB_POS_TYPE && fmt_r |->
		o_tx_data == `RFB_TYPE_EXPL)
		else $error("explicit frame carries a wrong type byte");
	AST_CSUM: assert property ( // RULE5
		hs && o_tx_last |-> 8'(chk_r + o_tx_data) == `RFB_CSUM_BASE)
		else $error("checksum does not close the byte sum");
	AST_ADDR: assert property ( // RULE6
		o_tx_valid && pos_r == `RFB_POS_ADDR_MSB |-> o_tx_data == src_r[63:56])
		else $error("address does not start with its top byte");
	AST_ADDR_LSB: assert property ( // RULE6
		o_tx_valid && pos_r == `RFB_POS_ADDR_LSB |-> o_tx_data == src_r[7:0])
		else $error("address does not end with its low byte");
	AST_OPT: assert property ( // RULE7
		o_tx_valid && pos_r == data_pos - 16'd1 |->
		o_tx_data[1:0] == {opt_r[`RFB_OPT_BCAST_BIT], opt_r[`RFB_OPT_ACK_BIT]})
		else $error("options byte misplaces ack or broadcast");
	AST_METH: assert property ( // RULE8
		o_tx_valid && pos_r == data_pos - 16'd1 |->
		o_tx_data[7:6] == opt_r[`RFB_OPT_METH_LSB +: 2])
		else $error("options byte misplaces the delivery method");
	AST_EP: assert property ( // RULE9
		o_tx_valid && fmt_r && pos_r == `RFB_POS_SRC_EP |-> o_tx_data == sep_r)
		else $error("source endpoint misplaced");
	AST_DST: assert property ( // RULE10
		o_tx_valid && fmt_r && pos_r == `RFB_POS_DST_EP |-> o_tx_data == dep_r)
		else $error("destination endpoint misplaced");
	AST_CLU: assert property ( // RULE11
		hs && fmt_r && pos_r == `RFB_POS_CLU_HI |-> o_tx_data == clu_r[15:8]
		##[1:4] o_tx_valid && o_tx_data == clu_r[7:0])
		else $error("cluster id bytes misplaced");
	AST_PRO: assert property ( // RULE12
		hs && fmt_r && pos_r == `RFB_POS_PRO_HI |-> o_tx_data == pro_r[15:8]
		##[1:4] o_tx_valid && o_tx_data == pro_r[7:0])
		else $error("profile id bytes misplaced");
	AST_RSV: assert property ( // RULE13
		hs && pos_r == `RFB_POS_RSV_HI |-> o_tx_data == `RFB_RSV_HI
		##[1:4] o_tx_valid && o_tx_data == `RFB_RSV_LO)
		else $error("reserved bytes wrong");
	AST_STALL: assert property (
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("byte changed while stalled");

endmodule // rfb_frame_builder

// ---- tb/rfb_host_model.sv ----
// host model: drains frames from the builder and checks each checksum
// assumes the builder's byte handshake and one clock
`timescale 1ns/1ns
module rfb_host_model (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_slow,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_last,
	output logic            o_tx_ready
);
	logic [7:0] frm [0:63];
	int         cnt;
	int         flen;
	int         nfr;
	logic [7:0] sum;
	logic       csum_ok;

	// one byte per handshake; slow mode stalls every other cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			cnt <= 0;
			flen <= 0;
			nfr <= 0;
			sum <= 8'h00;
			csum_ok <= 1'b0;
			o_tx_ready <= 1'b0;
		end else begin
			o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
			if (i_tx_valid && o_tx_ready) begin
				frm[cnt] <= i_tx_data;
				sum <= (cnt < 3) ? 8'h00 : sum + i_tx_data;
				cnt <= cnt + 1;
				if (i_tx_last) begin
					// sum from type through checksum must be 0xff
					csum_ok <= (8'(sum + i_tx_data) == 8'hff);
					flen <= cnt + 1;
					nfr <= nfr + 1;
					cnt <= 0;
				end
			end
		end
	end
endmodule // rfb_host_model

// ---- tb/testbench.sv ----
// bench of the frame builder: table of packets, host model on uart side
// assumes DEPTH of 16 so one row fills the payload store exactly
`timescale 1ns/1ns
module testbench;
	typedef struct packed {
		logic        fmt;
		logic [63:0] addr;
		logic        ack;
		logic        bcast;
		logic [1:0]  meth;
		logic [7:0]  sep;
		logic [7:0]  dep;
		logic [15:0] clu;
		logic [15:0] pro;
		logic [7:0]  n;
		logic [7:0]  base;
	} rfb_row_t;

	logic        clk_sys, rst_n, fmt, start, ack, bcast, valid, last, slow;
	logic [63:0] addr;
	logic [1:0]  meth;
	logic [7:0]  sep, dep, data, tx_data;
	logic [15:0] clu, pro;
	logic        rx_ready, busy, tx_valid, tx_last, tx_ready;
	logic [7:0]  exp_q [$];
	rfb_row_t    rows [0:3];
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	rfb_frame_builder #(.DEPTH(16)) i_dut (
		.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_api_output_format_select(fmt), .i_rx_start(start),
		.i_rx_src_addr(addr), .i_rx_ack(ack), .i_rx_bcast(bcast),
		.i_rx_method(meth), .i_rx_src_ep(sep), .i_rx_dst_ep(dep),
		.i_rx_cluster(clu), .i_rx_profile(pro), .i_rx_valid(valid),
		.i_rx_data(data), .i_rx_last(last), .o_rx_ready(rx_ready),
		.o_busy(busy), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
		.o_tx_last(tx_last), .i_tx_ready(tx_ready)
	);

	rfb_host_model i_host (
		.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_slow(slow),
		.i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.i_tx_last(tx_last), .o_tx_ready(tx_ready)
	);

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] want,
			input string what);
		cmp_count++;
		if (got !== want) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h want %h", $time, what,
				got, want);
		end
	endtask

	// stored frame bytes lo..hi-1 against the expected frame
	task automatic chk_span(input int lo, input int hi, input string what);
		for (int k = lo; k < hi; k++)
			chk8(i_host.frm[k], exp_q[k], what);
	endtask

	// expected frame worked out field by field from the row
	task automatic build(input rfb_row_t r);
		logic [7:0] body [$];
		logic [7:0] s;
		body = {r.fmt ? 8'h91 : 8'h90};
		for (int k = 7; k >= 0; k--) body.push_back(r.addr[8*k +: 8]);
		body.push_back(8'hff);
		body.push_back(8'hfe);
		if (r.fmt)
			body = {body, r.sep, r.dep, r.clu[15:8], r.clu[7:0],
				r.pro[15:8], r.pro[7:0]};
		body.push_back({r.meth, 4'h0, r.bcast, r.ack});
		for (int k = 0; k < r.n; k++) body.push_back(r.base + 8'(k));
		s = 8'hff;
		foreach (body[k]) s -= body[k];
		exp_q = {8'h7e, 8'(body.size() >> 8), 8'(body.size()), body, s};
	endtask

	// stray byte first, format flipped after start, optional start in busy
	task automatic send(input rfb_row_t r, input logic bump);
		int t;
		int n0;
		int o;
		n0 = i_host.nfr;
		build(r);
		o = r.fmt ? 20 : 14;
		valid <= 1'b1;
		data <= 8'haa;
		@(posedge clk_sys);
		valid <= 1'b0;
		start <= 1'b1;
		{fmt, addr, ack} <= {r.fmt, r.addr, r.ack};
		{bcast, meth} <= {r.bcast, r.meth};
		{sep, dep, clu, pro} <= {r.sep, r.dep, r.clu, r.pro};
		@(posedge clk_sys);
		start <= 1'b0;
		fmt <= ~r.fmt;
		for (int k = 0; k < r.n; k++) begin
			valid <= 1'b1;
			data <= r.base + 8'(k);
			last <= (k == r.n - 1);
			t = 0;
			do begin
				@(posedge clk_sys);
				t++;
			end while (!rx_ready && t < 50);
		end
		valid <= 1'b0;
		last <= 1'b0;
		start <= bump;
		@(posedge clk_sys);
		start <= 1'b0;
		chk8({6'h00, busy, rx_ready}, 8'h02, "capture end");
		t = 0;
		while (i_host.nfr == n0 && t < 2000) begin
			@(posedge clk_sys);
			t++;
		end
		repeat (8) @(posedge clk_sys);
		chk8(8'(i_host.nfr - n0), 8'h01, "frames");
		chk8(8'(i_host.flen), 8'(exp_q.size()), "length");
		chk_span(0, 4, "head");
		chk_span(4, 14, "addr");
		chk_span(14, o, "ids");
		chk_span(o, o + 1, "options");
		chk_span(o + 1, exp_q.size(), "data");
		chk8({7'h00, i_host.csum_ok}, 8'h01, "checksum");
		chk8({6'h00, busy, rx_ready}, 8'h00, "idle");
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// hang guard: far above the five frames plus reset
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		{rst_n, fmt, start, ack, bcast, valid, last, slow} = 8'h00;
		{addr, meth, sep, dep, data, clu, pro} = '0;
		rows[0] = {1'b0, 64'h0013a20040522baa, 1'b1, 1'b0, 2'h1, 8'h00,
			8'h00, 16'h0000, 16'h0000, 8'h06, 8'h52};
		rows[1] = {1'b1, 64'h0013a20040522baa, 1'b0, 1'b1, 2'h2, 8'he0,
			8'he0, 16'h2211, 16'hc105, 8'h06, 8'h52};
		rows[2] = {1'b0, 64'h8877665544332211, 1'b1, 1'b1, 2'h3, 8'h00,
			8'h00, 16'h0000, 16'h0000, 8'h01, 8'hf0};
		rows[3] = {1'b1, 64'hfedcba9876543210, 1'b1, 1'b0, 2'h0, 8'h01,
			8'hfe, 16'hffff, 16'h0001, 8'h10, 8'hf8};
		repeat (5) @(posedge clk_sys);
		#1;
		chk8({4'h0, rx_ready, busy, tx_valid, tx_last}, 8'h00, "reset");
		@(posedge clk_sys);
		rst_n <= 1'b1;
		// odd rows drained by a stalling host
		foreach (rows[i]) begin
			slow <= i[0];
			send(rows[i], i == 2);
		end
		// reset cut into a running frame, then a whole frame must follow
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		valid <= 1'b1;
		last <= 1'b1;
		@(posedge clk_sys);
		valid <= 1'b0;
		last <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk8({6'h00, busy, tx_valid}, 8'h03, "mid frame");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk8({4'h0, rx_ready, busy, tx_valid, tx_last}, 8'h00, "mid reset");
		rst_n <= 1'b1;
		send(rows[0], 1'b0);
		complete_run();
	end
endmodule // testbench
